//--- hw/tmrec_map.vh
`ifndef TMREC_MAP_VH
`define TMREC_MAP_VH
// Register word addresses
`define TMREC_ADDR_MODE     8'h8B
`define TMREC_ADDR_PRESC    8'h8C
`define TMREC_ADDR_TIMER    8'h8D
`define TMREC_ADDR_PINSEL   8'h8E
`define TMREC_ADDR_STATUS   8'h8F
`define TMREC_ADDR_MASK     8'h90
// Mode register fields
`define TMREC_MODE_LO       0
`define TMREC_MODE_HI       1
`define TMREC_BIT_EDGE      3
`define TMREC_BIT_RUN       4
`define TMREC_MODE_EVENT    2'h2
// Status bit positions
`define TMREC_ST_UNDER      0
`define TMREC_ST_EXT        1
// Reset values
`define TMREC_RST_MODE      8'h00
`define TMREC_RST_PRESC     8'hFF
`define TMREC_RST_TIMER     8'hFF
`endif

//--- hw/tmrec_sync.v
// Two-stage synchroniser for pin inputs
module tmrec_sync
#(
  parameter WIDTH = 2
)
(
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

//--- hw/tmrec_top.v
// Added by the designer: strobed register access.
`include "tmrec_map.vh"
module tmrec_top
#(
  parameter WIDTH = 8
)
(
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  input  wire             event_input_a,
  input  wire             event_input_b,
  output wire             irq,
  output reg              timer_irq_pulse,
  output reg              ext_irq_pulse
);

  wire [1:0]       pins_sync;
  reg  [7:0]       timer_mode_control;
  reg              event_pin_select;
  reg  [WIDTH-1:0] presc_reload;
  reg  [WIDTH-1:0] presc_count;
  reg  [WIDTH-1:0] timer_reload;
  reg  [WIDTH-1:0] timer_count;
  reg  [1:0]       status;
  reg  [1:0]       mask;
  reg  [1:0]       pins_prev;
  reg              presc_pend;
  reg              timer_pend;
  reg  [3:0]       wr_phase;
  reg              next_edge_sel;

  // Staging of a running write, one-hot
  localparam [3:0] STG_IDLE   = 4'h1;
  localparam [3:0] STG_RELOAD = 4'h2;
  localparam [3:0] STG_LOAD   = 4'h4;
  localparam [3:0] STG_SKIP   = 4'h8;

  // Pins cross into sys_clk before use
  tmrec_sync
  #(
    .WIDTH (2)
  )
  u_sync
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({event_input_b, event_input_a}),
    .sync_out (pins_sync)
  );

  // Edge detect with polarity select
  function edge_hit;
    input cur;
    input prev;
    input fall;
    begin
      edge_hit = fall ? (prev & ~cur) : (cur & ~prev);
    end
  endfunction

  // One step down; both counters share it
  function [WIDTH-1:0] dec_one;
    input [WIDTH-1:0] val;
    begin
      dec_one = val - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  endfunction

  // Write strobe aimed at one register
  function wr_at;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_at = wr & (addr == target);
    end
  endfunction

  wire edge_pol  = timer_mode_control[`TMREC_BIT_EDGE];
  wire run       = timer_mode_control[`TMREC_BIT_RUN];
  wire event_md  = timer_mode_control[`TMREC_MODE_HI:`TMREC_MODE_LO]
                   == `TMREC_MODE_EVENT;

  wire sel_cur  = event_pin_select ? pins_sync[1] : pins_sync[0];
  wire sel_prev = event_pin_select ? pins_prev[1] : pins_prev[0];
  wire src_evt  = edge_hit(sel_cur, sel_prev, edge_pol);

  wire ext_evt = edge_hit(pins_sync[0], pins_prev[0], edge_pol) |
                 edge_hit(pins_sync[1], pins_prev[1], edge_pol);

  wire count_en = run & event_md;
  wire tick     = count_en & src_evt & (wr_phase == STG_IDLE);

  wire presc_zero = (presc_count == {WIDTH{1'b0}});
  wire timer_zero = (timer_count == {WIDTH{1'b0}});
  wire timer_unf  = tick & presc_zero & timer_zero;

  // Register write decode
  wire wr_presc  = wr_at(reg_wr, reg_addr, `TMREC_ADDR_PRESC);
  wire wr_timer  = wr_at(reg_wr, reg_addr, `TMREC_ADDR_TIMER);
  wire wr_mode   = wr_at(reg_wr, reg_addr, `TMREC_ADDR_MODE);
  wire wr_pinsel = wr_at(reg_wr, reg_addr, `TMREC_ADDR_PINSEL);
  wire wr_mask   = wr_at(reg_wr, reg_addr, `TMREC_ADDR_MASK);
  wire wr_status = wr_at(reg_wr, reg_addr, `TMREC_ADDR_STATUS);

  // polarity change makes a pseudo edge
  always @*
  begin
    next_edge_sel = 1'b0;
    if (wr_mode && (reg_wdata[`TMREC_BIT_EDGE] != edge_pol))
      next_edge_sel = sel_cur;
  end

  // Pin history
  always @(posedge sys_clk)
  begin
    if (rst)
      pins_prev <= 2'h0;
    else
      pins_prev <= pins_sync;
  end

  // Control registers
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      timer_mode_control <= `TMREC_RST_MODE;
      event_pin_select   <= 1'b0;
      mask               <= 2'h0;
    end
    else
    begin
      if (wr_mode)
        timer_mode_control <= reg_wdata;
      if (wr_pinsel)
        event_pin_select <= reg_wdata[0];
      if (wr_mask)
        mask <= reg_wdata[1:0];
    end
  end

  // Staged write sequence while running
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_phase   <= STG_IDLE;
      presc_pend <= 1'b0;
      timer_pend <= 1'b0;
    end
    else if (!count_en)
    begin
      // Stopping drops a half-done staging
      wr_phase   <= STG_IDLE;
      presc_pend <= 1'b0;
      timer_pend <= 1'b0;
    end
    else if (wr_presc || wr_timer)
    begin
      wr_phase   <= STG_RELOAD;
      presc_pend <= presc_pend | wr_presc;
      timer_pend <= timer_pend | wr_timer;
    end
    else if (src_evt)
    begin
      case (wr_phase)
        STG_RELOAD: wr_phase <= STG_LOAD;
        STG_LOAD:   wr_phase <= STG_SKIP;
        STG_SKIP:
        begin
          // Third event is swallowed, not counted
          wr_phase   <= STG_IDLE;
          presc_pend <= 1'b0;
          timer_pend <= 1'b0;
        end
        default:    wr_phase <= STG_IDLE;
      endcase
    end
  end

  // Held write data for the staged path
  reg [WIDTH-1:0] presc_hold;
  reg [WIDTH-1:0] timer_hold;

  // Counters and reloads
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      presc_reload <= `TMREC_RST_PRESC;
      presc_count  <= `TMREC_RST_PRESC;
      timer_reload <= `TMREC_RST_TIMER;
      timer_count  <= `TMREC_RST_TIMER;
      presc_hold   <= `TMREC_RST_PRESC;
      timer_hold   <= `TMREC_RST_TIMER;
    end
    else
    begin
      if (wr_presc)
        presc_hold <= reg_wdata[WIDTH-1:0];
      if (wr_timer)
        timer_hold <= reg_wdata[WIDTH-1:0];
      if (!count_en)
      begin
        if (wr_presc)
        begin
          presc_reload <= reg_wdata[WIDTH-1:0];
          presc_count  <= reg_wdata[WIDTH-1:0];
        end
        if (wr_timer)
        begin
          timer_reload <= reg_wdata[WIDTH-1:0];
          timer_count  <= reg_wdata[WIDTH-1:0];
        end
      end
      else if (src_evt && wr_phase == STG_RELOAD)
      begin
        if (presc_pend)
          presc_reload <= presc_hold;
        if (timer_pend)
          timer_reload <= timer_hold;
      end
      else if (src_evt && wr_phase == STG_LOAD)
      begin
        if (presc_pend)
          presc_count <= presc_reload;
        if (timer_pend)
          timer_count <= timer_reload;
      end
      else if (tick)
      begin
        // reload gives n+1 and m+1 division
        if (presc_zero)
        begin
          presc_count <= presc_reload;
          if (timer_zero)
            timer_count <= timer_reload;
          else
            timer_count <= dec_one(timer_count);
        end
        else
          presc_count <= dec_one(presc_count);
      end
    end
  end

  // Events that set status bits this cycle
  wire [1:0] status_set = {event_md & (ext_evt | next_edge_sel), timer_unf};

  // Sticky status, set beats clear
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      status          <= 2'h0;
      timer_irq_pulse <= 1'b0;
      ext_irq_pulse   <= 1'b0;
    end
    else
    begin
      timer_irq_pulse <= timer_unf;
      ext_irq_pulse   <= status_set[`TMREC_ST_EXT];
      // Clear by one, but a fresh event wins
      if (wr_status)
        status <= (status & ~reg_wdata[1:0]) | status_set;
      else
        status <= status | status_set;
    end
  end

  assign irq = |(status & mask);

  // Live counts for read-back; bus is eight bits, so WIDTH stays 8
  wire [7:0] presc_rd = presc_count;
  wire [7:0] timer_rd = timer_count;

  // Read port, one cycle latency
  always @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `TMREC_ADDR_MODE)
        reg_rdata <= timer_mode_control;
      else if (reg_addr == `TMREC_ADDR_PRESC)
        reg_rdata <= presc_rd;
      else if (reg_addr == `TMREC_ADDR_TIMER)
        reg_rdata <= timer_rd;
      else if (reg_addr == `TMREC_ADDR_PINSEL)
        reg_rdata <= {7'h00, event_pin_select};
      else if (reg_addr == `TMREC_ADDR_STATUS)
        reg_rdata <= {6'h00, status};
      else if (reg_addr == `TMREC_ADDR_MASK)
        reg_rdata <= {6'h00, mask};
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule

//--- bench/tmrec_props.sv
module tmrec_props
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       event_input_a,
  input wire logic       event_input_b,
  input wire logic       irq,
  input wire logic       timer_irq_pulse,
  input wire logic       ext_irq_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Read data only in the cycle after a strobe
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_unmap_zero: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (reg_wr && reg_addr == 8'h8B ##1
    !reg_wr ##1 reg_rd && reg_addr == 8'h8B |=>
    reg_rdata == $past(reg_wdata, 3))
    else $error("mode register readback wrong");
  a_tpulse_single: assert property (timer_irq_pulse |=> !timer_irq_pulse)
    else $error("timer pulse too long");
  a_epulse_single: assert property (ext_irq_pulse |=> !ext_irq_pulse)
    else $error("ext pulse too long");
  // Level rises only with a new event or a register write
  a_irq_rise: assert property ($rose(irq) |->
    timer_irq_pulse || ext_irq_pulse || $past(reg_wr))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq fell without write");
  a_status_bits: assert property (
    reg_rd && reg_addr == 8'h8F |=> reg_rdata[7:2] == 6'h00)
    else $error("status spare bits set");
endmodule

//--- bench/tmrec_event_src.sv
module tmrec_event_src
(
  input  wire logic sys_clk,
  output logic      pin_a,
  output logic      pin_b
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // one rise, one fall
  // Low time covers sync plus detect latency before the caller reads
  task automatic pulse(input logic sel, input int cnt);
    repeat (cnt)
    begin
      @(posedge sys_clk);
      if (sel) pin_b <= 1'b1;
      else pin_a <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
  endtask
endmodule

//--- bench/tmrec_tb_top.sv
module tmrec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v, n, m, b;
  logic [7:0] tp_cnt = 8'h00, ep_cnt = 8'h00, e;
  logic irq, tpl, epl, pa, pb;
  logic [31:0] seed = 32'd53000;
  int num_errors = 0, check_count = 0, k, j, p;

  always #12.5 sys_clk = ~sys_clk;
  // Underflow and ext-pin pulses tallied for count checks
  always @(posedge sys_clk) if (tpl === 1'b1) tp_cnt <= tp_cnt + 8'h01;
  always @(posedge sys_clk) if (epl === 1'b1) ep_cnt <= ep_cnt + 8'h01;

  tmrec_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_input_a(pa), .event_input_b(pb),
    .irq(irq), .timer_irq_pulse(tpl), .ext_irq_pulse(epl));
  tmrec_event_src u_src (.sys_clk(sys_clk), .pin_a(pa), .pin_b(pb));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Live count left after j events, divide step, top value
  function automatic logic [7:0] left(int jj, int dv, int top);
    return 8'(top - jj / dv);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h8B, v); chk(v, 8'h00);
    rd(8'h8C, v); chk(v, 8'hFF);
    rd(8'h00, v); chk(v, 8'h00);
    for (p = 0; p < 2; p++)
    begin
      n = 8'(rnd() % 4);
      m = 8'(rnd() % 4);
      wr(8'h8B, 8'h02);
      wr(8'h8C, n); wr(8'h8D, m); wr(8'h8E, 8'(p));
      u_src.pulse(p[0], 2);
      rd(8'h8D, v); chk(v, m);
      wr(8'h90, 8'h01);
      // Run with rising, then falling edges on the other pin
      wr(8'h8B, p ? 8'h1A : 8'h12);
      rd(8'h8B, v); chk(v, p ? 8'h1A : 8'h12);
      b = tp_cnt;
      k = (n + 1) * (m + 1);
      j = rnd() % k;
      e = ep_cnt;
      u_src.pulse(!p[0], 2);
      chk(ep_cnt - e, 8'h02);
      u_src.pulse(p[0], j);
      rd(8'h8C, v); chk(v, left(j % (n + 1), 1, n));
      rd(8'h8D, v); chk(v, left(j, n + 1, m));
      u_src.pulse(p[0], k - j - 1);
      chk(tp_cnt - b, 8'h00);
      chk({7'h00, irq}, 8'h00);
      u_src.pulse(p[0], 1);
      chk(tp_cnt - b, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rd(8'h8D, v); chk(v, m);
      wr(8'h8F, 8'h03);
      rd(8'h8F, v); chk({7'h00, v[0]}, 8'h00);
    end
    v = 8'(rnd() % 4) + 8'h04;
    wr(8'h8D, v);
    u_src.pulse(1'b1, 3);
    rd(8'h8D, b); chk(b, v);
    rd(8'h8C, b); chk(b, n);
    wr(8'h8B, 8'h0A);
    u_src.pulse(1'b1, 2);
    rd(8'h8D, b); chk(b, v);
    rd(8'h8C, b); chk(b, n);
    give_verdict();
  end
endmodule

bind tmrec_top tmrec_props u_props (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_input_a(event_input_a),
  .event_input_b(event_input_b), .irq(irq),
  .timer_irq_pulse(timer_irq_pulse), .ext_irq_pulse(ext_irq_pulse));
